// [verilog/seq_pkg.sv]
package seq_pkg;

  // ----------------------------------------------------------------
  // Channel and timing constants
  // ----------------------------------------------------------------
  localparam int NUM_CH          = 4;
  localparam int IDX_W           = 2;
  localparam int CLK_MHZ         = 100;
  localparam int STEP_DELAY_US   = 250;
  localparam int STEP_DELAY_CYC  = STEP_DELAY_US * CLK_MHZ;
  localparam int DLY_W           = 24;
  localparam int DATA_W          = 32;
  localparam int ADDR_W          = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL       = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK   = 4'hC;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int ST_EN_LSB     = 0;
  localparam int ST_REG_LSB    = 4;
  localparam int ST_DIS_LSB    = 8;
  localparam int ST_DONE_BIT   = 12;
  localparam int ST_PG_BIT     = 13;
  localparam int ST_SUPPLY_BIT = 14;
  localparam int ST_STATE_LSB  = 16;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  localparam int IRQ_W         = 3;
  localparam int IRQ_UP_DONE   = 0;
  localparam int IRQ_DOWN_DONE = 1;
  localparam int IRQ_RAIL_LOST = 2;

  localparam logic [IDX_W-1:0] FIRST_CH = 2'h0;
  localparam logic [IDX_W-1:0] IDX_ONE  = 2'h1;

  typedef enum logic [2:0]
  {
    S_IDLE    = 3'b000,
    S_UP_DLY  = 3'b001,
    S_UP_WAIT = 3'b010,
    S_FIN_DLY = 3'b011,
    S_DONE    = 3'b100,
    S_DN_DLY  = 3'b101,
    S_DN_WAIT = 3'b110,
    S_END_DLY = 3'b111
  } seq_state_e;

endpackage : seq_pkg

// [verilog/chan_if.sv]
interface chan_if #(
  parameter int N = 4
);
  logic         supply_ok;
  logic         up_lvl;
  logic         down_n_lvl;
  logic [N-1:0] in_reg;
  logic [N-1:0] turnoff;

  modport sync
  (
    output supply_ok,
    output up_lvl,
    output down_n_lvl,
    output in_reg,
    output turnoff
  );

  modport seq
  (
    input supply_ok,
    input up_lvl,
    input down_n_lvl,
    input in_reg,
    input turnoff
  );
endinterface : chan_if

// [verilog/monitor_sync.sv]
module monitor_sync #(
  parameter int N = 4
)
(
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         supply_ok_pin,
  input  wire logic         up_pin,
  input  wire logic         down_n_pin,
  input  wire logic [N-1:0] cmp_pin,
  input  wire logic [N-1:0] turnoff_pin,
  chan_if.sync              chan
);
  localparam int W = 2 * N + 3;

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ----------------------------------------------------------------
  // Two-flop synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  always_comb
  begin
    meta_d = {supply_ok_pin, up_pin, down_n_pin, cmp_pin, turnoff_pin};
    sync_d = meta_q;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d; // RULE14
      sync_q <= sync_d; // RULE14
    end
  end

  assign chan.supply_ok  = sync_q[W-1];
  assign chan.up_lvl     = sync_q[W-2];
  assign chan.down_n_lvl = sync_q[W-3];
  assign chan.in_reg     = sync_q[2*N-1:N];
  assign chan.turnoff    = sync_q[N-1:0];
endmodule : monitor_sync

// [verilog/step_timer.sv]
module step_timer #(
  parameter int W = 24
)
(
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              expired
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         busy_q;
  logic         busy_d;
  logic         exp_q;
  logic         exp_d;

  // ----------------------------------------------------------------
  // Down counter; restart cancels a running count
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    exp_d  = 1'b0;
    if (start)
    begin
      cnt_d  = load;
      busy_d = 1'b1;
    end
    else if (busy_q)
    begin
      if (cnt_q == '0)
      begin
        busy_d = 1'b0;
        exp_d  = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      exp_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      exp_q  <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule : step_timer

// [verilog/rail_monitor_sequence_order.sv]
// How it works
// RULE1: Outputs stay low until sequence-up rising edge
// RULE2: Enables rise in order channel 1 to 4
// RULE3: Enables fall in order channel 4 to 1
// RULE4: Channel 1 can never be disabled
// RULE5: A disabled channel disables all higher channels
// RULE6: Turn-off flag marks channels 2-4 disabled
// RULE7: Disabled channels skip the step delay
// RULE8: System fixes disable flags before power-up
// RULE9: In regulation above threshold; hysteresis then on
// RULE10: Out of regulation only below off level
// RULE11: Next enable waits for step delay expiry
// RULE12: Sequence up starts on trigger rising edge
// RULE13: Supply below lockout forces all outputs low; code clears only the enables and flags, not hysteresis_source or irq
// RULE14: Comparator and disable inputs are synchronised
module rail_monitor_sequence_order #(
  parameter int N                 = seq_pkg::NUM_CH,
  parameter int STEP_DELAY_CYCLES = seq_pkg::STEP_DELAY_CYC
)
(
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic                       supply_ok_in,
  input  wire logic                       seq_up_trig,
  input  wire logic                       seq_down_trig_n,
  input  wire logic [N-1:0]               rail_monitor_in,
  input  wire logic [N-1:0]               rail_turnoff_in,
  output logic [N-1:0]                    rail_enable_out,
  output logic [N-1:0]                    hysteresis_source,
  output logic                            sequence_complete_flag,
  output logic                            all_rails_good_flag,
  input  wire logic [seq_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [seq_pkg::DATA_W-1:0] avs_writedata,
  output logic [seq_pkg::DATA_W-1:0]      avs_readdata,
  output logic                            avs_waitrequest,
  output logic                            irq
);
  import seq_pkg::*;

  if (N < 2 || N > NUM_CH) begin : bad_n
    $error("N must lie between 2 and 4");
  end
  if (STEP_DELAY_CYCLES < 0 || STEP_DELAY_CYCLES >= (1 << DLY_W))
  begin : bad_delay
    $error("STEP_DELAY_CYCLES does not fit the timer");
  end

  localparam logic [DLY_W-1:0] DLY_RESET = DLY_W'(STEP_DELAY_CYCLES);

  // ----------------------------------------------------------------
  // Input synchronisation and channel masks
  // ----------------------------------------------------------------
  chan_if #(.N(N)) chan ();

  monitor_sync #(.N(N)) u_sync
  (
    .mclk          (mclk),
    .reset         (reset),
    .supply_ok_pin (supply_ok_in),
    .up_pin        (seq_up_trig),
    .down_n_pin    (seq_down_trig_n),
    .cmp_pin       (rail_monitor_in),
    .turnoff_pin   (rail_turnoff_in),
    .chan          (chan)
  );

  logic [N-1:0]     dis;
  logic [IDX_W-1:0] last_ch;

  assign dis[0] = 1'b0; // RULE4
  for (genvar k = 1; k < N; k++) begin : g_cascade
    assign dis[k] = chan.turnoff[k] | dis[k-1]; // RULE5 RULE6
  end

  // Disables cascade upward, so the live count names the top channel
  assign last_ch = IDX_W'($countones(~dis) - 1); // RULE7

  // ----------------------------------------------------------------
  // Step delay timer
  // ----------------------------------------------------------------
  logic             tmr_start;
  logic             tmr_exp;
  logic [DLY_W-1:0] dly_q;
  logic [DLY_W-1:0] dly_d;

  step_timer #(.W(DLY_W)) u_timer
  (
    .mclk    (mclk),
    .reset   (reset),
    .start   (tmr_start),
    .load    (dly_q),
    .expired (tmr_exp)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  seq_state_e       st_q;
  seq_state_e       st_d;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx_d;
  logic [N-1:0]     en_q;
  logic [N-1:0]     en_d;
  logic [N-1:0]     hys_q;
  logic [N-1:0]     hys_d;
  logic             done_q;
  logic             done_d;
  logic             pg_q;
  logic             pg_d;
  logic             up_prev_q;
  logic             dn_prev_q;
  logic             up_rise;
  logic             dn_fall;
  logic [IRQ_W-1:0] evt;

  // Edge detect only: a trigger held high never restarts a sequence
  assign up_rise = chan.up_lvl & ~up_prev_q; // RULE12
  assign dn_fall = ~chan.down_n_lvl & dn_prev_q;

  always_comb
  begin
    st_d      = st_q;
    idx_d     = idx_q;
    en_d      = en_q;
    done_d    = done_q;
    pg_d      = pg_q;
    tmr_start = 1'b0;
    evt       = '0;
    hys_d     = chan.in_reg; // RULE9
    case (st_q)
      S_IDLE:
      begin
        if (up_rise)
        begin
          idx_d     = FIRST_CH;
          tmr_start = 1'b1;
          st_d      = S_UP_DLY; // RULE1
        end
      end
      S_UP_DLY, S_DN_DLY:
      begin
        if (tmr_exp)
        begin
          en_d[idx_q] = (st_q == S_UP_DLY); // RULE11
          st_d        = (st_q == S_UP_DLY) ? S_UP_WAIT : S_DN_WAIT;
        end
      end
      S_UP_WAIT:
      begin
        if (chan.in_reg[idx_q])
        begin
          // Index may wrap past the last channel; nothing reads it then
          tmr_start = 1'b1;
          idx_d     = idx_q + IDX_ONE; // RULE2
          st_d      = (idx_q == last_ch) ? S_FIN_DLY : S_UP_DLY; // RULE7
        end
      end
      S_FIN_DLY:
      begin
        if (tmr_exp)
        begin
          done_d           = 1'b1;
          pg_d             = 1'b1;
          evt[IRQ_UP_DONE] = 1'b1;
          st_d             = S_DONE;
        end
      end
      S_DONE:
      begin
        if ((en_q & ~chan.in_reg) != '0)
        begin
          evt[IRQ_RAIL_LOST] = 1'b1; // RULE10
        end
      end
      S_DN_WAIT:
      begin
        if (!chan.in_reg[idx_q]) // RULE10
        begin
          tmr_start = 1'b1;
          idx_d     = idx_q - IDX_ONE; // RULE3
          st_d      = (idx_q == FIRST_CH) ? S_END_DLY : S_DN_DLY;
        end
      end
      S_END_DLY:
      begin
        if (tmr_exp)
        begin
          done_d             = 1'b0;
          evt[IRQ_DOWN_DONE] = 1'b1;
          st_d               = S_IDLE;
        end
      end
      default:
      begin
        st_d = S_IDLE;
      end
    endcase
    // Down may abort an unfinished sequence up as well
    if (dn_fall && (st_q == S_UP_DLY || st_q == S_UP_WAIT ||
                    st_q == S_FIN_DLY || st_q == S_DONE))
    begin
      pg_d      = 1'b0;
      idx_d     = last_ch; // RULE3
      tmr_start = 1'b1;
      st_d      = S_DN_DLY;
    end
    if (!chan.supply_ok)
    begin
      st_d      = S_IDLE; // RULE13
      en_d      = '0;
      done_d    = 1'b0;
      pg_d      = 1'b0;
      tmr_start = 1'b0;
      evt       = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_q      <= S_IDLE;
      idx_q     <= FIRST_CH;
      en_q      <= '0;
      hys_q     <= '0;
      done_q    <= 1'b0;
      pg_q      <= 1'b0;
      up_prev_q <= 1'b0;
      dn_prev_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      idx_q     <= idx_d;
      en_q      <= en_d;
      hys_q     <= hys_d;
      done_q    <= done_d;
      pg_q      <= pg_d;
      up_prev_q <= chan.up_lvl;
      dn_prev_q <= chan.down_n_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave and interrupts
  // ----------------------------------------------------------------
  logic                wait_q;
  logic                wait_d;
  logic [DATA_W-1:0]   rdata_q;
  logic [DATA_W-1:0]   rdata_d;
  logic [IRQ_W-1:0]    ist_q;
  logic [IRQ_W-1:0]    ist_d;
  logic [IRQ_W-1:0]    imask_q;
  logic [IRQ_W-1:0]    imask_d;
  logic                irq_q;
  logic                irq_d;
  logic                acc;
  logic [DATA_W-1:0]   status;

  // One wait cycle per access keeps read data registered
  assign acc = (avs_read | avs_write) & ~wait_q;

  always_comb
  begin
    status                = '0;
    status[ST_EN_LSB+:N]  = en_q;
    status[ST_REG_LSB+:N] = chan.in_reg;
    status[ST_DIS_LSB+:N] = dis;
    status[ST_DONE_BIT]   = done_q;
    status[ST_PG_BIT]     = pg_q;
    status[ST_SUPPLY_BIT] = chan.supply_ok;
    status[ST_STATE_LSB+:3] = st_q;
    wait_d  = ~((avs_read | avs_write) & wait_q);
    rdata_d = rdata_q;
    dly_d   = dly_q;
    imask_d = imask_q;
    ist_d   = ist_q;
    if (avs_read && wait_q)
    begin
      case (avs_address)
        OFF_CTRL:       rdata_d = DATA_W'(dly_q);
        OFF_STATUS:     rdata_d = status;
        OFF_INT_STATUS: rdata_d = DATA_W'(ist_q);
        OFF_INT_MASK:   rdata_d = DATA_W'(imask_q);
        default:        rdata_d = '0;
      endcase
    end
    if (acc && avs_write && avs_address == OFF_CTRL)
    begin
      dly_d = avs_writedata[DLY_W-1:0];
    end
    if (acc && avs_write && avs_address == OFF_INT_MASK)
    begin
      imask_d = avs_writedata[IRQ_W-1:0];
    end
    if (acc && avs_read && avs_address == OFF_INT_STATUS)
    begin
      ist_d = ist_q & ~rdata_q[IRQ_W-1:0];
    end
    // Clear only what was read; set after, so no event is lost
    ist_d = ist_d | evt;
    irq_d = (ist_d & imask_d) != '0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
      dly_q   <= DLY_RESET;
      imask_q <= '0;
      ist_q   <= '0;
      irq_q   <= 1'b0;
    end
    else
    begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      dly_q   <= dly_d;
      imask_q <= imask_d;
      ist_q   <= ist_d;
      irq_q   <= irq_d;
    end
  end

  assign rail_enable_out        = en_q;
  assign hysteresis_source      = hys_q;
  assign sequence_complete_flag = done_q;
  assign all_rails_good_flag    = pg_q;
  assign avs_readdata           = rdata_q;
  assign avs_waitrequest        = wait_q;
  assign irq                    = irq_q;
endmodule : rail_monitor_sequence_order

// [sim/rail_seq_monitor.sv]
module rail_seq_monitor #(
  parameter int N                 = 4,
  parameter int STEP_DELAY_CYCLES = 8
)
(
  input wire logic         mclk,
  input wire logic         reset,
  input wire logic         supply_ok_in,
  input wire logic         seq_up_trig,
  input wire logic [N-1:0] rail_monitor_in,
  input wire logic [N-1:0] rail_turnoff_in,
  input wire logic [N-1:0] rail_enable_out,
  input wire logic [N-1:0] hysteresis_source,
  input wire logic         sequence_complete_flag,
  input wire logic         all_rails_good_flag
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Windows cover the two-flop sync plus the output register
  sequence supply_gone;
    !supply_ok_in [*5];
  endsequence
  sequence mon_high;
    (rail_monitor_in[0] && supply_ok_in) [*8];
  endsequence
  sequence mon_low;
    !rail_monitor_in[0] [*5];
  endsequence

  AST_LOCKOUT_EN: assert property (supply_gone |-> rail_enable_out == '0)
    else $error("enables high without supply");
  AST_LOCKOUT_FLAGS: assert property (supply_gone |->
    !sequence_complete_flag && !all_rails_good_flag)
    else $error("flags high without supply");
  AST_ORDER: assert property
    ((rail_enable_out & (rail_enable_out + 1'b1)) == '0)
    else $error("enables out of channel order");
  AST_CH1_USED: assert property (all_rails_good_flag |-> rail_enable_out[0])
    else $error("power good without first rail");
  AST_CASCADE: assert property
    (rail_turnoff_in[1] [*5] |-> rail_enable_out[N-1:1] == '0)
    else $error("disabled channels enabled");
  AST_HYS_ON: assert property (mon_high |-> hysteresis_source[0])
    else $error("hysteresis missing in regulation");
  AST_HYS_OFF: assert property (mon_low |-> !hysteresis_source[0])
    else $error("hysteresis on below level");
  AST_STEP_WAIT: assert property ($rose(rail_enable_out[1]) |->
    $past(rail_monitor_in[0], STEP_DELAY_CYCLES))
    else $error("next rail enabled before step delay");
  AST_UP_EDGE: assert property ($rose(rail_enable_out[0]) |->
    $past(seq_up_trig, 3))
    else $error("sequence up without trigger");
  AST_FLAGS_TOGETHER: assert property ($rose(sequence_complete_flag) |->
    $rose(all_rails_good_flag))
    else $error("complete and good not together");
  AST_GOOD_FIRST: assert property ($fell(sequence_complete_flag) |->
    !all_rails_good_flag)
    else $error("power good outlived complete flag");
endmodule : rail_seq_monitor

bind rail_monitor_sequence_order rail_seq_monitor #(
  .N(N),
  .STEP_DELAY_CYCLES(STEP_DELAY_CYCLES)
) chk (
  .mclk(mclk), .reset(reset), .supply_ok_in(supply_ok_in),
  .seq_up_trig(seq_up_trig), .rail_monitor_in(rail_monitor_in),
  .rail_turnoff_in(rail_turnoff_in), .rail_enable_out(rail_enable_out),
  .hysteresis_source(hysteresis_source),
  .sequence_complete_flag(sequence_complete_flag),
  .all_rails_good_flag(all_rails_good_flag)
);

// [sim/rail_partner.sv]
module rail_partner
(
  input  wire logic       mclk,
  input  wire logic [3:0] en,
  input  wire logic [7:0] lag,
  output logic      [3:0] mon
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Regulators: output follows enable after lag + 1 cycles
  // ----------------------------------------------------------------
  int cnt_q [4] = '{0, 0, 0, 0};

  initial mon = 4'h0;
  always @(posedge mclk)
    for (int k = 0; k < 4; k++)
    begin
      if (en[k] == mon[k])
        cnt_q[k] <= 0;
      else if (cnt_q[k] >= lag)
        mon[k] <= en[k];
      else
        cnt_q[k] <= cnt_q[k] + 1;
    end
endmodule : rail_partner

// [sim/test_rail_monitor_sequence_order.sv]
module test_rail_monitor_sequence_order;
  timeunit 1ns;
  timeprecision 1ps;
  import seq_pkg::*;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam int D = 8;
  typedef struct packed {logic [3:0] off; logic [3:0] en; logic [7:0] lag;}
    row_s;
  localparam row_s ROWS [6] = '{'{4'h0, 4'hF, 8'h02}, '{4'h2, 4'h1, 8'h02},
    '{4'h4, 4'h3, 8'h14}, '{4'h8, 4'h7, 8'h00}, '{4'h1, 4'hF, 8'h05},
    '{4'hC, 4'h3, 8'h01}};
  logic        mclk = 1'b0, reset = 1'b1, supply_ok_in = 1'b1;
  logic        seq_up_trig = 1'b0, seq_down_trig_n = 1'b1, irq;
  logic [3:0]  rail_monitor_in, rail_turnoff_in = 4'h0, rail_enable_out;
  logic [3:0]  hysteresis_source, avs_address = 4'h0;
  logic        sequence_complete_flag, all_rails_good_flag;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
  logic [7:0]  lag = 8'h02;
  int          n_errors = 0, comparisons = 0, waited, cyc = 0, times [6];

  rail_monitor_sequence_order #(.N(4), .STEP_DELAY_CYCLES(D)) uut (
    .mclk(mclk), .reset(reset), .supply_ok_in(supply_ok_in),
    .seq_up_trig(seq_up_trig), .seq_down_trig_n(seq_down_trig_n),
    .rail_monitor_in(rail_monitor_in), .rail_turnoff_in(rail_turnoff_in),
    .rail_enable_out(rail_enable_out), .hysteresis_source(hysteresis_source),
    .sequence_complete_flag(sequence_complete_flag),
    .all_rails_good_flag(all_rails_good_flag), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  rail_partner regs (.mclk(mclk), .en(rail_enable_out), .lag(lag),
    .mon(rail_monitor_in));

  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // Held until waitrequest is seen low; released on the taking edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && t < 50)
    begin
      @(posedge mclk);
      t++;
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check(t < 50, 1'b1);
  endtask : bus

  task automatic wait_flag(input logic lvl);
    waited = 0;
    while (sequence_complete_flag !== lvl && waited < 2000)
    begin
      @(negedge mclk);
      waited++;
    end
    check(waited < 2000, 1'b1);
    repeat (3) @(negedge mclk);
  endtask : wait_flag

  task automatic end_of_test;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (30) @(negedge mclk);
    check({rail_enable_out, sequence_complete_flag, all_rails_good_flag}, 0);
    bus(1'b0, OFF_CTRL, 32'h0);
    check(rdata, D);
    bus(1'b0, 4'h2, 32'h0);
    check(rdata, 32'h0);
    bus(1'b1, OFF_INT_MASK, 32'h1);
    foreach (ROWS[i])
    begin
      @(posedge mclk);
      rail_turnoff_in <= ROWS[i].off;
      lag <= ROWS[i].lag;
      repeat (10) @(posedge mclk);
      seq_up_trig <= 1'b1;
      wait_flag(1'b1);
      times[i] = waited;
      check(rail_enable_out, ROWS[i].en);
      check(hysteresis_source, ROWS[i].en);
      check({all_rails_good_flag, irq}, 2'b11);
      bus(1'b0, OFF_INT_STATUS, 32'h0);
      check(rdata, 32'h1);
      @(posedge mclk);
      seq_up_trig <= 1'b0;
      seq_down_trig_n <= 1'b0;
      wait_flag(1'b0);
      check({rail_enable_out, all_rails_good_flag, irq}, 0);
      check(hysteresis_source, 4'h0);
      bus(1'b0, OFF_INT_STATUS, 32'h0);
      check(rdata, 32'h2);
      seq_down_trig_n <= 1'b1;
      $display("row %0d finished", i);
    end
    check(times[0] - times[1] > 3 * D, 1'b1);
    // Level held high after a down must not restart the sequence
    seq_up_trig <= 1'b1;
    wait_flag(1'b1);
    @(posedge mclk);
    seq_down_trig_n <= 1'b0;
    wait_flag(1'b0);
    repeat (40) @(negedge mclk);
    check(rail_enable_out, 4'h0);
    $display("level trigger test finished");
    @(posedge mclk);
    seq_up_trig <= 1'b0;
    seq_down_trig_n <= 1'b1;
    repeat (5) @(posedge mclk);
    seq_up_trig <= 1'b1;
    repeat (40) @(posedge mclk);
    supply_ok_in <= 1'b0;
    repeat (8) @(negedge mclk);
    check({rail_enable_out, sequence_complete_flag, all_rails_good_flag}, 0);
    @(posedge mclk);
    supply_ok_in <= 1'b1;
    repeat (40) @(negedge mclk);
    check(rail_enable_out, 4'h0);
    bus(1'b0, OFF_STATUS, 32'h0);
    check({rdata[ST_SUPPLY_BIT], rdata[3:0]}, 5'h10);
    $display("supply loss test finished");
    end_of_test();
  end
endmodule : test_rail_monitor_sequence_order
